/* logic/bcfi_consts.vh */
// Purpose: constants for the binary command frame interpreter
// Assumes: byte-wide receive and transmit streams
// Notes:   definitions only
`ifndef BCFI_CONSTS_VH
`define BCFI_CONSTS_VH
// ==========================================================
// frame geometry
`define BCFI_SER_LEN      4'h9
`define BCFI_CAN_LEN      4'h7
`define BCFI_CKS_POS      4'h8
// ==========================================================
// status codes
`define BCFI_ST_OK        8'h64
`define BCFI_ST_STORED    8'h65
`define BCFI_ST_CKSUM     8'h01
`define BCFI_ST_BADCMD    8'h02
`define BCFI_ST_BADTYPE   8'h03
`define BCFI_ST_BADVAL    8'h04
`define BCFI_ST_LOCKED    8'h05
`define BCFI_ST_NOTAVAIL  8'h06
// ==========================================================
// idle timeout, in microseconds, and derived cycles at 250 MHz
`define BCFI_IDLE_US      1000
`define BCFI_CLK_MHZ      250
`define BCFI_IDLE_CYC     (`BCFI_IDLE_US * `BCFI_CLK_MHZ)
`endif

/* logic/bcfi_skid.v */
// Purpose: two-entry buffer on the reply byte stream
// Assumes: single clock
// Notes:   full throughput, stalls lose no byte
`timescale 1ns/10ps
module bcfi_skid
#(
  parameter W = 8
)
(
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem_reg [0:1];
  reg         wp_reg;
  reg         rp_reg;
  reg [1:0]   cnt_reg;
  wire        push;
  wire        pop;
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= {W{1'b0}};
      mem_reg[1] <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule // bcfi_skid

/* logic/bcfi_top.v */
// Purpose: slave interpreter for fixed-length binary command frames
// Assumes: byte stream from a uart, usb or can front end; an executor
//          that answers each command with a status and a value
// Notes:   can_mode selects 7-byte frames without address or checksum
//
// Functional notes
// - never transmit unless a command addressed to us was received
// - stay receiving; transmit enable only while a reply goes out
// - exactly one reply per command, after execution completes
// - payload: command, type, motor/bank, 4-byte value msb first
// - serial/usb frames add leading address and trailing checksum
// - checksum is 8-bit sum of all preceding bytes, address included
// - reply: reply addr, module addr, status, command, value, checksum
// - reply checksum is 8-bit wrapping sum of the other reply bytes
// - can frames drop address and checksum; checksum check skipped
// - can replies drop address and checksum; id is reply address
// - status 100 on successful execution
// - status 101 when command stored into program memory
// - errors: 1 checksum, 2 command, 3 type, 4 value, 5 lock, 6 n/a
// - download commands into program memory and run them standalone
`timescale 1ns/10ps
`include "bcfi_consts.vh"
module bcfi_top
#(
  parameter        PROG_DEPTH = 256,
  parameter        PROG_AW    = 8,
  parameter [31:0] IDLE_CYC   = `BCFI_IDLE_CYC
)
(
  input  wire        clk,
  input  wire        arst_n,
  input  wire        can_mode,
  input  wire [7:0]  module_addr,
  input  wire [7:0]  reply_addr,
  input  wire        prog_lock,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output reg         tx_en,
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg         tx_last,
  output reg         exe_req,
  output reg  [7:0]  exe_cmd,
  output reg  [7:0]  exe_type,
  output reg  [7:0]  exe_bank,
  output reg  [31:0] exe_value,
  output reg         exe_standalone,
  input  wire        exe_done,
  input  wire [7:0]  exe_status,
  input  wire [31:0] exe_result
);
  // ==========================================================
  // command codes handled locally
  localparam [7:0] CMD_DL_START = 8'h84;
  localparam [7:0] CMD_DL_END   = 8'h85;
  localparam [7:0] CMD_RUN      = 8'h81;
  localparam [7:0] CMD_STOP     = 8'h80;
  localparam [2:0] S_RX   = 3'h0;
  localparam [2:0] S_EXE  = 3'h1;
  localparam [2:0] S_TX   = 3'h2;
  localparam [2:0] S_DRN  = 3'h3;
  localparam [2:0] S_RUN  = 3'h4;
  // ==========================================================
  // receive side
  reg [7:0]  frm_reg [0:8];
  reg [3:0]  idx_reg;
  reg [7:0]  sum_reg;
  reg [31:0] idle_reg;
  reg [2:0]  st_reg;
  reg        dl_reg;
  reg [7:0]  stat_reg;
  reg [31:0] res_reg;
  reg [3:0]  tix_reg;
  reg [7:0]  tsum_reg;
  reg [PROG_AW-1:0] wp_reg;
  reg [PROG_AW-1:0] pc_reg;
  reg [55:0] prog_mem [0:PROG_DEPTH-1];
  reg        standalone_reg;
  wire [3:0] flen;
  wire [3:0] base;
  wire [7:0] fcmd;
  wire       frame_end;
  wire       sum_ok;
  wire [7:0] b_data;
  reg        b_valid;
  wire       b_ready;
  wire [7:0] q_data;
  wire       q_valid;
  reg  [7:0] rbyte;
  reg  [3:0] rlen;
  integer    k;
  assign flen = can_mode ? `BCFI_CAN_LEN : `BCFI_SER_LEN;
  assign base = can_mode ? 4'h0 : 4'h1;
  assign fcmd = frm_reg[base];
  // host bytes still land while a stored command executes
  assign frame_end = (st_reg == S_RX || st_reg == S_RUN) & rx_valid &
                     (idx_reg == flen - 4'h1);
  // received checksum equals running sum of all earlier bytes
  assign sum_ok = can_mode | (rx_data == sum_reg);
  // ==========================================================
  // reply byte mux
  always @*
  begin
    rlen  = can_mode ? 4'h6 : `BCFI_SER_LEN;
    rbyte = 8'h00;
    case (can_mode ? tix_reg + 4'h2 : tix_reg)
      4'h0:    rbyte = reply_addr;
      4'h1:    rbyte = module_addr;
      4'h2:    rbyte = stat_reg;
      4'h3:    rbyte = frm_reg[base];
      4'h4:    rbyte = res_reg[31:24];
      4'h5:    rbyte = res_reg[23:16];
      4'h6:    rbyte = res_reg[15:8];
      4'h7:    rbyte = res_reg[7:0];
      4'h8:    rbyte = tsum_reg;
      default: rbyte = 8'h00;
    endcase
  end
  assign b_data = rbyte;
  bcfi_skid #(.W(8)) u_buf
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_data   (b_data),
    .in_valid  (b_valid),
    .in_ready  (b_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (tx_ready | ~tx_valid)
  );
  always @*
    b_valid = (st_reg == S_TX);
  // ==========================================================
  // main sequencer
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_reg        <= 4'h0;
      sum_reg        <= 8'h00;
      idle_reg       <= 32'h0;
      st_reg         <= S_RX;
      dl_reg         <= 1'b0;
      stat_reg       <= 8'h00;
      res_reg        <= 32'h0;
      tix_reg        <= 4'h0;
      tsum_reg       <= 8'h00;
      wp_reg         <= {PROG_AW{1'b0}};
      pc_reg         <= {PROG_AW{1'b0}};
      standalone_reg <= 1'b0;
      exe_req        <= 1'b0;
      exe_cmd        <= 8'h00;
      exe_type       <= 8'h00;
      exe_bank       <= 8'h00;
      exe_value      <= 32'h0;
      exe_standalone <= 1'b0;
      tx_en          <= 1'b0;
      for (k = 0; k < 9; k = k + 1)
        frm_reg[k] <= 8'h00;
    end
    else
    begin
      exe_req <= 1'b0;
      case (st_reg)
        S_RX, S_RUN:
        begin
          tx_en <= 1'b0;
          // standalone result is not replied; bus stays quiet
          if (st_reg == S_RUN && exe_done)
            st_reg <= S_RX;
          if (rx_valid)
          begin
            frm_reg[idx_reg] <= rx_data;
            sum_reg  <= sum_reg + rx_data;
            idx_reg  <= idx_reg + 4'h1;
            idle_reg <= 32'h0;
            if (frame_end)
            begin
              idx_reg <= 4'h0;
              sum_reg <= 8'h00;
              if (can_mode || frm_reg[0] == module_addr)
              begin
                res_reg <= 32'h0;
                if (!sum_ok)
                begin
                  stat_reg <= `BCFI_ST_CKSUM;
                  st_reg   <= S_TX;
                end
                else if (fcmd == CMD_DL_START)
                begin
                  if (prog_lock)
                    stat_reg <= `BCFI_ST_LOCKED;
                  else
                  begin
                    dl_reg   <= 1'b1;
                    wp_reg   <= {PROG_AW{1'b0}};
                    stat_reg <= `BCFI_ST_OK;
                  end
                  st_reg <= S_TX;
                end
                else if (dl_reg)
                begin
                  // store instead of execute while downloading
                  prog_mem[wp_reg] <= {frm_reg[base], frm_reg[base+4'h1],
                    frm_reg[base+4'h2], frm_reg[base+4'h3],
                    frm_reg[base+4'h4], frm_reg[base+4'h5],
                    can_mode ? rx_data : frm_reg[7]};
                  wp_reg   <= wp_reg + {{(PROG_AW-1){1'b0}}, 1'b1};
                  if (fcmd == CMD_DL_END)
                    dl_reg <= 1'b0;
                  stat_reg <= `BCFI_ST_STORED;
                  st_reg   <= S_TX;
                end
                else if (fcmd == CMD_RUN)
                begin
                  pc_reg         <= {PROG_AW{1'b0}};
                  standalone_reg <= 1'b1;
                  stat_reg       <= `BCFI_ST_OK;
                  st_reg         <= S_TX;
                end
                else if (fcmd == CMD_STOP)
                begin
                  standalone_reg <= 1'b0;
                  stat_reg       <= `BCFI_ST_OK;
                  st_reg         <= S_TX;
                end
                else if (standalone_reg)
                begin
                  stat_reg <= `BCFI_ST_NOTAVAIL;
                  st_reg   <= S_TX;
                end
                else
                begin
                  // cmd, type, bank, value msb first
                  exe_cmd        <= frm_reg[base];
                  exe_type       <= frm_reg[base+4'h1];
                  exe_bank       <= frm_reg[base+4'h2];
                  exe_value      <= can_mode ?
                    {frm_reg[3], frm_reg[4], frm_reg[5], rx_data} :
                    {frm_reg[4], frm_reg[5], frm_reg[6], frm_reg[7]};
                  exe_standalone <= 1'b0;
                  exe_req        <= 1'b1;
                  st_reg         <= S_EXE;
                end
              end
            end
          end
          else if (idx_reg != 4'h0)
          begin
            if (idle_reg >= IDLE_CYC - 32'h1)
            begin
              idx_reg  <= 4'h0;
              sum_reg  <= 8'h00;
              idle_reg <= 32'h0;
            end
            else
              idle_reg <= idle_reg + 32'h1;
          end
          else if (standalone_reg && st_reg == S_RX)
          begin
            // replay stored commands without a host
            {exe_cmd, exe_type, exe_bank, exe_value} <= prog_mem[pc_reg];
            exe_standalone <= 1'b1;
            exe_req        <= 1'b1;
            pc_reg <= (pc_reg + {{(PROG_AW-1){1'b0}}, 1'b1} == wp_reg) ?
              {PROG_AW{1'b0}} : pc_reg + {{(PROG_AW-1){1'b0}}, 1'b1};
            st_reg <= S_RUN;
          end
          tix_reg  <= 4'h0;
          tsum_reg <= 8'h00;
        end
        S_EXE:
        begin
          if (exe_done)
          begin
            stat_reg <= exe_status;
            res_reg  <= exe_result;
            st_reg   <= S_TX;
          end
        end
        S_TX:
        begin
          tx_en <= 1'b1;
          if (b_ready)
          begin
            tsum_reg <= tsum_reg + rbyte;
            tix_reg  <= tix_reg + 4'h1;
            if (tix_reg == rlen - 4'h1)
              st_reg <= S_DRN;
          end
        end
        S_DRN:
        begin
          if (!q_valid && !tx_valid)
            st_reg <= S_RX;
        end
        default: st_reg <= S_RX;
      endcase
    end
  end
  // ==========================================================
  // output stage; tx_last marks the final reply byte
  reg [3:0] ocnt_reg;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      ocnt_reg <= 4'h0;
    end
    else if (tx_ready | ~tx_valid)
    begin
      tx_valid <= q_valid;
      tx_data  <= q_data;
      tx_last  <= q_valid & (ocnt_reg == rlen - 4'h1);
      if (q_valid)
        ocnt_reg <= (ocnt_reg == rlen - 4'h1) ? 4'h0 : ocnt_reg + 4'h1;
    end
  end
endmodule // bcfi_top

/* verification/bcfi_host.sv */
// Purpose: host model issuing command frames and taking replies
// Assumes: one clock, bytes driven at the falling edge
// Notes:   slow drops tx_ready for one cycle in every four
`timescale 1ns/10ps
module bcfi_host
(
  input  wire        clk,
  input  wire        slow,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  output logic       tx_ready,
  input  wire  [7:0] tx_data,
  input  wire        tx_valid,
  input  wire        tx_last
);
  // ==========================================================
  // reply capture
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  integer     nlast = 0;
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // stalls exercise the reply buffer
  always @(negedge clk)
  begin
    ph       <= ph + 2'h1;
    tx_ready <= !slow || ph != 2'h0;
  end
  always @(posedge clk)
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      nlast = nlast + (tx_last ? 1 : 0);
    end
  // ==========================================================
  // frame sender, cnt cuts the frame short
  task automatic send_cmd(input logic [7:0] addr, input logic [7:0] cmd,
                          input logic [31:0] val, input logic bad,
                          input logic can, input integer cnt);
    logic [7:0] b[$];
    logic [7:0] sum;
    b = {cmd, 8'h01, 8'h02, val[31:24], val[23:16], val[15:8], val[7:0]};
    if (!can)
      b.push_front(addr);
    sum = 8'h00;
    foreach (b[i])
      sum = sum + b[i];
    if (!can)
      b.push_back(sum ^ {7'h00, bad});
    got.delete();
    for (int i = 0; i < cnt && i < b.size(); i++)
    begin
      @(negedge clk);
      rx_data  = b[i];
      rx_valid = 1'b1;
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule // bcfi_host

/* verification/bcfi_sva.sv */
// Purpose: port assertions for the frame interpreter
// Assumes: one clock, reset arst_n
// Notes:   bound to bcfi_top
`timescale 1ns/10ps
module bcfi_sva
(
  input wire       clk,
  input wire       arst_n,
  input wire       can_mode,
  input wire [7:0] reply_addr,
  input wire       rx_valid,
  input wire       tx_en,
  input wire [7:0] tx_data,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       tx_last,
  input wire       exe_req,
  input wire       exe_standalone
);
  // ==========================================================
  // helper state
  reg       seen_reg;
  reg [3:0] beat_reg;
  reg [7:0] sum_reg;
  wire      beat = tx_valid && tx_ready;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seen_reg <= 1'b0;
      beat_reg <= 4'h0;
      sum_reg  <= 8'h00;
    end
    else
    begin
      if (rx_valid)
        seen_reg <= 1'b1;
      if (beat)
      begin
        beat_reg <= tx_last ? 4'h0 : beat_reg + 4'h1;
        sum_reg  <= tx_last ? 8'h00 : sum_reg + tx_data;
      end
      if (beat && tx_last)
        seen_reg <= 1'b0;
    end
  end
  // ==========================================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_last_beat;
    tx_valid && tx_ready && tx_last;
  endsequence
  sequence s_quiet;
    !tx_valid [*8];
  endsequence
  a_tx_in_drive: assert property (tx_valid |-> tx_en)
    else $error("reply byte without drive enable");
  a_tx_en_release: assert property (s_last_beat |-> ##[1:4] !tx_en)
    else $error("drive enable held after reply");
  a_no_unsolicited: assert property ($rose(tx_en) |-> seen_reg)
    else $error("transmit without a received frame");
  a_single_reply: assert property (s_last_beat |=> s_quiet)
    else $error("second reply after last byte");
  a_stall_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  a_reply_length: assert property (s_last_beat |->
    can_mode || beat_reg == 4'h8)
    else $error("serial reply not nine bytes");
  a_reply_head: assert property (beat && beat_reg == 4'h0
    && !can_mode |-> tx_data == reply_addr)
    else $error("reply does not open with reply address");
  a_reply_cksum: assert property (beat && tx_last && !can_mode
    |-> tx_data == sum_reg)
    else $error("reply checksum wrong");
  a_req_pulse: assert property (exe_req |=> !exe_req)
    else $error("request longer than one cycle");
  a_req_after_rx: assert property (exe_req && !exe_standalone
    |-> $past(rx_valid) || $past(rx_valid, 2))
    else $error("host request not after a frame byte");
endmodule // bcfi_sva

bind bcfi_top bcfi_sva i_sva (.clk(clk), .arst_n(arst_n), .can_mode(can_mode),
  .reply_addr(reply_addr), .rx_valid(rx_valid), .tx_en(tx_en),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_last(tx_last), .exe_req(exe_req), .exe_standalone(exe_standalone));

/* verification/bcfi_top_test.sv */
// Purpose: self-checking bench for the frame interpreter
// Assumes: 250 MHz clock, short idle timeout
// Notes:   executor answers four cycles after a request
`timescale 1ns/10ps
module bcfi_top_test;
  logic        clk = 1'b0, arst_n = 1'b0, can_mode = 1'b0, prog_lock = 1'b0;
  logic        slow = 1'b0, exe_done = 1'b0;
  logic [7:0]  module_addr = 8'h03, reply_addr = 8'h02, ex_st = 8'h64;
  logic [31:0] ex_val = 32'h80FF_0102;
  logic [2:0]  lat = 3'h0;
  logic [31:0] sa_val = 32'h0;
  wire  [7:0]  rx_data, tx_data, exe_cmd, exe_type, exe_bank;
  wire  [31:0] exe_value;
  wire         rx_valid, tx_en, tx_valid, tx_ready, tx_last, exe_req, exe_sa;
  integer      error_cnt = 0, comparisons = 0, req_cnt = 0, sa_cnt = 0;
  localparam   SV = 32'hA5C3_0F81;
  always #2 clk = ~clk;
  bcfi_top #(.IDLE_CYC(32'd50)) i_dut (.clk(clk), .arst_n(arst_n),
    .can_mode(can_mode), .module_addr(module_addr), .reply_addr(reply_addr),
    .prog_lock(prog_lock), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_en(tx_en), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_last(tx_last), .exe_req(exe_req),
    .exe_cmd(exe_cmd), .exe_type(exe_type), .exe_bank(exe_bank),
    .exe_value(exe_value), .exe_standalone(exe_sa), .exe_done(exe_done),
    .exe_status(ex_st), .exe_result(ex_val));
  bcfi_host i_host (.clk(clk), .slow(slow), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last));
  // ==========================================================
  // executor stand-in
  always @(negedge clk)
  begin
    exe_done = (lat == 3'h1);
    req_cnt  = req_cnt + (exe_req ? 1 : 0);
    sa_cnt   = sa_cnt + (exe_req && exe_sa ? 1 : 0);
    if (exe_req && exe_sa)
      sa_val = exe_value;
    lat      = exe_req ? 3'h4 : (lat != 3'h0 ? lat - 3'h1 : 3'h0);
  end
  // ==========================================================
  // checking
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] a, input logic [31:0] b);
    comparisons = comparisons + 1;
    if (a !== b)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h want %h", $time, a, b);
    end
  endtask
  // want: 0 no reply, 1 head only, 2 whole reply
  task automatic xact(input logic [7:0] addr, input logic [7:0] cmd,
                      input logic bad, input logic [7:0] st,
                      input logic [31:0] val, input logic [1:0] want);
    logic [7:0] e[$];
    logic [7:0] sum;
    integer     k, n, off;
    e = {st, cmd, val[31:24], val[23:16], val[15:8], val[7:0]};
    if (!can_mode)
    begin
      e.push_front(module_addr);
      e.push_front(reply_addr);
      sum = 8'h00;
      foreach (e[i])
        sum = sum + e[i];
      e.push_back(sum);
    end
    k = i_host.nlast;
    n = 0;
    i_host.send_cmd(addr, cmd, SV, bad, can_mode, 9);
    while (i_host.nlast == k && n < (want == 2'd0 ? 40 : 300))
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (want == 2'd0)
    begin
      check(i_host.nlast, k);
      return;
    end
    if (n >= 300)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
    if (!can_mode)
      check(32'(i_host.got.size()), 32'd9);
    off = i_host.got.size() - e.size();
    for (int i = 0; i < e.size(); i++)
      if (want == 2'd2 || i < e.size() - 5)
        check({24'h0, i_host.got[off + i]}, {24'h0, e[i]});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_status;
    logic [7:0] codes[4] = '{8'h64, 8'h02, 8'h03, 8'h04};
    slow = 1'b1;
    foreach (codes[i])
    begin
      ex_st = codes[i];
      xact(8'h03, 8'h06, 1'b0, codes[i], ex_val, 2'd2);
    end
    ex_st = 8'h64;
    check({8'h00, exe_cmd, exe_type, exe_bank}, 32'h0006_0102);
    check(exe_value, SV);
  endtask
  task automatic t_reject;
    integer r;
    r = req_cnt;
    xact(8'h07, 8'h06, 1'b0, 8'h64, ex_val, 2'd0);
    xact(8'h03, 8'h06, 1'b1, 8'h01, 32'h0, 2'd2);
    check(req_cnt, r);
    i_host.send_cmd(8'h03, 8'h06, SV, 1'b0, 1'b0, 4);
    repeat (60) @(negedge clk);
    xact(8'h03, 8'h06, 1'b0, 8'h64, ex_val, 2'd2);
  endtask
  task automatic t_program;
    integer r;
    prog_lock = 1'b1;
    xact(8'h03, 8'h84, 1'b0, 8'h05, 32'h0, 2'd1);
    prog_lock = 1'b0;
    xact(8'h03, 8'h84, 1'b0, 8'h64, 32'h0, 2'd1);
    r = req_cnt;
    xact(8'h03, 8'h05, 1'b0, 8'h65, 32'h0, 2'd1);
    xact(8'h03, 8'h85, 1'b0, 8'h65, 32'h0, 2'd1);
    check(req_cnt, r);
    xact(8'h03, 8'h81, 1'b0, 8'h64, 32'h0, 2'd1);
    repeat (30) @(negedge clk);
    check(32'(sa_cnt != 0), 32'h1);
    check(sa_val, SV);
    xact(8'h03, 8'h02, 1'b0, 8'h06, 32'h0, 2'd1);
    xact(8'h03, 8'h80, 1'b0, 8'h64, 32'h0, 2'd1);
  endtask
  task automatic t_can;
    can_mode = 1'b1;
    slow = 1'b0;
    xact(8'h00, 8'h06, 1'b0, 8'h64, ex_val, 2'd2);
    can_mode = 1'b0;
  endtask
  // ==========================================================
  // main sequence, host waits for each reply
  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_status;
    t_reject;
    t_program;
    t_can;
    report_and_stop;
  end
endmodule // bcfi_top_test
